// ---- hdl/mqpr_pkg.sv ----
// Purpose: constants and types for the packet-mode queue read port
// Assumes: 36-bit words, 32 local queues of 16 words each
// Notes:   register offsets are byte addresses on a 32-bit AXI4-Lite bus
package mqpr_pkg;
    localparam int NQ = 32;
    localparam int DEPTH = 16;
    localparam int DW = 36;
    localparam int SW = 8;
    // marker bit positions
    localparam int END_BIT = 35;
    localparam int START_BIT = 34;
    localparam int NEAR_BIT = 33;
    // read clock edges from selection to first word
    localparam logic [1:0] SWITCH_EDGES = 2'h2;
    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LIMIT = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0c;
    localparam logic [7:0] OFS_PRDY = 8'h10;
    localparam logic [7:0] OFS_CUR = 8'h14;
    // control fields
    localparam int CTRL_QCNT_L = 0;
    localparam int CTRL_RW_L = 8;
    localparam int CTRL_WW_L = 10;
    localparam int CTRL_CID_L = 12;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_7f1f;
    localparam logic [31:0] CTRL_RST = 32'h0000_0a1f;
    // limit register fields
    localparam int LIM_IDX_L = 16;
    localparam logic [4:0] LIM_RST = 5'h10;
    // status bits
    localparam int ST_PKT_IN = 0;
    localparam int ST_END_OUT = 1;
    localparam int ST_WR_REF = 2;
    localparam int ST_NEAR = 3;
    localparam int NST = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {MQPR_W9, MQPR_W18, MQPR_W36} mqpr_width_t;

    function automatic logic [35:0] mqpr_wmask(input logic [1:0] w);
        case (mqpr_width_t'(w))
            MQPR_W9: return 36'h0_0000_01ff;
            MQPR_W18: return 36'h0_0003_ffff;
            default: return 36'hf_ffff_ffff;
        endcase
    endfunction
endpackage

// ---- hdl/mqpr_read_port.sv ----
// Purpose: packet store of many queues with a packet-mode read port
// Assumes: port clocks are pins, sampled and edge-detected on aclk
// Notes:   output_valid_flag high means no valid word, as on the pin
`timescale 1ns/100ps
`default_nettype none
module mqpr_read_port (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             irq,
    input  wire logic        write_port_clock,
    input  wire logic        write_enable,
    input  wire logic [7:0]  write_queue_sel,
    input  wire logic [35:0] write_data,
    output logic             full_flag,
    input  wire logic        read_port_clock,
    input  wire logic        read_enable,
    input  wire logic [7:0]  read_queue_sel,
    output logic [35:0]      read_data,
    output logic             output_valid_flag,
    output logic             packet_ready_flag,
    output logic [31:0]      packet_ready_bus
);
    localparam int NQ = mqpr_pkg::NQ;
    localparam int PW = 4 + 2 * mqpr_pkg::SW + mqpr_pkg::DW;
    logic [PW-1:0]   s1, s2;
    logic            wc3, rc3, w_ck, r_ck, w_en, r_en, w_edge, r_edge;
    logic            w_ok, r_ok, wr_go, cur_ok, fp, sel_chg, rdy, do_pop;
    logic            aw_h, w_h, wr_do, rd_err;
    logic [7:0]      w_sel, r_sel, cur_sel, aw_a;
    logic [35:0]     w_raw, w_in, rword;
    logic [31:0]     ctrl, w_d, bm, rd_mux;
    logic [4:0]      qcnt, lim_idx, cq;
    logic [2:0]      cid;
    logic [1:0]      rw, ww, sw, esince;
    logic [4:0]      lim [NQ], cnt [NQ], pk [NQ];
    logic [3:0]      wp [NQ], rp [NQ];
    logic [35:0]     mem [NQ*mqpr_pkg::DEPTH];
    logic [NQ-1:0]   push, pop, pk_nz;
    logic [mqpr_pkg::NST-1:0] stat, mask, ev, clr;

    // pin inputs pass two flip-flops before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= '0;
            s2 <= '0;
            wc3 <= 1'b0;
            rc3 <= 1'b0;
        end else begin
            s1 <= {write_port_clock, read_port_clock, write_enable, read_enable,
                   write_queue_sel, read_queue_sel, write_data};
            s2 <= s1;
            wc3 <= s2[PW-1];
            rc3 <= s2[PW-2];
        end
    end
    assign {w_ck, r_ck, w_en, r_en, w_sel, r_sel, w_raw} = s2;
    assign w_edge = w_ck & ~wc3;
    assign r_edge = r_ck & ~rc3;

    assign qcnt = ctrl[mqpr_pkg::CTRL_QCNT_L +: 5];
    assign rw = ctrl[mqpr_pkg::CTRL_RW_L +: 2];
    assign ww = ctrl[mqpr_pkg::CTRL_WW_L +: 2];
    assign cid = ctrl[mqpr_pkg::CTRL_CID_L +: 3];
    // selection decode: cascade id then local queue range
    assign w_ok = (w_sel[7:5] == cid) && (w_sel[4:0] <= qcnt);
    assign r_ok = (r_sel[7:5] == cid) && (r_sel[4:0] <= qcnt);
    assign w_in = w_raw & mqpr_pkg::mqpr_wmask(ww);
    assign wr_go = w_edge && w_en && w_ok && (cnt[w_sel[4:0]] < lim[w_sel[4:0]]);
    // per-queue pointers, fill and complete-packet counts
    for (genvar q = 0; q < NQ; q++) begin : g_q
        assign push[q] = wr_go && (w_sel[4:0] == 5'(q));
        assign pop[q] = do_pop && (cq == 5'(q));
        assign pk_nz[q] = (pk[q] != 5'h0);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                wp[q] <= 4'h0;
                rp[q] <= 4'h0;
                cnt[q] <= 5'h0;
                pk[q] <= 5'h0;
            end else begin
                wp[q] <= wp[q] + 4'(push[q]);
                rp[q] <= rp[q] + 4'(pop[q]);
                cnt[q] <= cnt[q] + 5'(push[q]) - 5'(pop[q]);
                pk[q] <= pk[q] + 5'(push[q] & w_in[mqpr_pkg::END_BIT])
                         - 5'(pop[q] & rword[mqpr_pkg::END_BIT]);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (wr_go) begin
            mem[{w_sel[4:0], wp[w_sel[4:0]]}] <= w_in;
        end
    end
    // read side: selection tracking and delivery
    assign cq = cur_sel[4:0];
    assign rword = mem[{cq, rp[cq]}];
    assign sel_chg = (r_sel != cur_sel);
    assign rdy = cur_ok && pk_nz[cq];
    assign do_pop = r_edge && !sel_chg && rdy && (sw == 2'h0) && (fp || r_en);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_sel <= 8'hff;
            cur_ok <= 1'b0;
            sw <= 2'h0;
            fp <= 1'b0;
        end else if (r_edge && sel_chg) begin
            cur_sel <= r_sel;
            cur_ok <= r_ok;
            sw <= mqpr_pkg::SWITCH_EDGES - 2'h1;
            fp <= 1'b1;
        end else begin
            if (r_edge && sw != 2'h0) begin
                sw <= sw - 2'h1;
            end
            if (do_pop) begin
                fp <= 1'b0;
            end
        end
    end
    // output word held until a ready queue delivers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_data <= 36'h0;
        end else if (do_pop) begin
            read_data <= rword & mqpr_pkg::mqpr_wmask(rw);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_valid_flag <= 1'b1;
        end else if (do_pop) begin
            output_valid_flag <= 1'b0;
        end else if (r_edge && sel_chg && !r_ok) begin
            output_valid_flag <= 1'b1;
        end else if (r_edge && !sel_chg && sw == 2'h0 && (fp || r_en)) begin
            output_valid_flag <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            packet_ready_bus <= '0;
            packet_ready_flag <= 1'b0;
            full_flag <= 1'b0;
        end else begin
            packet_ready_bus <= pk_nz;
            packet_ready_flag <= rdy;
            full_flag <= !w_ok || (cnt[w_sel[4:0]] >= lim[w_sel[4:0]]);
        end
    end
    // events and interrupt
    always_comb begin
        ev = '0;
        ev[mqpr_pkg::ST_PKT_IN] = wr_go && w_in[mqpr_pkg::END_BIT];
        ev[mqpr_pkg::ST_END_OUT] = do_pop && rword[mqpr_pkg::END_BIT];
        ev[mqpr_pkg::ST_WR_REF] = w_edge && w_en && !wr_go;
        ev[mqpr_pkg::ST_NEAR] = do_pop && rword[mqpr_pkg::NEAR_BIT];
    end
    assign clr = (wr_do && (aw_a & 8'hfc) == mqpr_pkg::OFS_STAT) ?
                 w_d[mqpr_pkg::NST-1:0] & bm[mqpr_pkg::NST-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat <= '0;
            irq <= 1'b0;
        end else begin
            stat <= (stat & ~clr) | ev;
            irq <= |(stat & mask);
        end
    end
    // axi4-lite write channel
    assign awready = !aw_h && !bvalid;
    assign wready = !w_h && !bvalid;
    assign wr_do = aw_h && w_h && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_h <= 1'b0;
            w_h <= 1'b0;
            aw_a <= 8'h0;
            w_d <= 32'h0;
            bm <= 32'h0;
            bvalid <= 1'b0;
            bresp <= mqpr_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_h <= 1'b1;
                aw_a <= awaddr;
            end
            if (wvalid && wready) begin
                w_h <= 1'b1;
                w_d <= wdata;
                bm <= {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
            end
            if (wr_do) begin
                aw_h <= 1'b0;
                w_h <= 1'b0;
                bvalid <= 1'b1;
                bresp <= ((aw_a & 8'hfc) > mqpr_pkg::OFS_CUR) ?
                         mqpr_pkg::RESP_SLVERR : mqpr_pkg::RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    // writable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= mqpr_pkg::CTRL_RST;
            mask <= '0;
            lim_idx <= 5'h0;
            for (int i = 0; i < NQ; i++) begin
                lim[i] <= mqpr_pkg::LIM_RST;
            end
        end else if (wr_do) begin
            unique case (aw_a & 8'hfc)
                mqpr_pkg::OFS_CTRL: begin
                    ctrl <= (ctrl & ~(bm & mqpr_pkg::CTRL_WMASK))
                            | (w_d & bm & mqpr_pkg::CTRL_WMASK);
                end
                mqpr_pkg::OFS_LIMIT: begin
                    lim_idx <= w_d[mqpr_pkg::LIM_IDX_L +: 5];
                    lim[w_d[mqpr_pkg::LIM_IDX_L +: 5]] <=
                        (w_d[4:0] > mqpr_pkg::LIM_RST) ? mqpr_pkg::LIM_RST : w_d[4:0];
                end
                mqpr_pkg::OFS_MASK: begin
                    mask <= (mask & ~bm[mqpr_pkg::NST-1:0])
                            | (w_d[mqpr_pkg::NST-1:0] & bm[mqpr_pkg::NST-1:0]);
                end
                default: ;
            endcase
        end
    end
    // axi4-lite read channel
    assign arready = !rvalid;
    always_comb begin
        rd_mux = 32'h0;
        rd_err = 1'b0;
        unique case (araddr & 8'hfc)
            mqpr_pkg::OFS_CTRL: rd_mux = ctrl;
            mqpr_pkg::OFS_LIMIT: rd_mux = {11'h0, lim_idx, 11'h0, lim[lim_idx]};
            mqpr_pkg::OFS_STAT: rd_mux = 32'(stat);
            mqpr_pkg::OFS_MASK: rd_mux = 32'(mask);
            mqpr_pkg::OFS_PRDY: rd_mux = packet_ready_bus;
            mqpr_pkg::OFS_CUR: rd_mux = {15'h0, output_valid_flag, cur_sel, 3'h0, cnt[cq]};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= mqpr_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_err ? mqpr_pkg::RESP_SLVERR : mqpr_pkg::RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
    // checks: read clock edges counted since the last switch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            esince <= 2'h3;
        end else if (r_edge && sel_chg) begin
            esince <= 2'h0;
        end else if (r_edge && esince != 2'h3) begin
            esince <= esince + 2'h1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_sel_ready;
        r_edge && !sel_chg && fp && rdy && esince == 2'h1;
    endsequence
    sequence s_park;
        r_edge && sel_chg && !r_ok;
    endsequence
    property p_first_on_time;
        s_sel_ready |-> do_pop ##1 !output_valid_flag;
    endproperty
    a_first_on_time: assert property (p_first_on_time) else $error("first word late");
    property p_first_not_early;
        do_pop && fp |-> esince >= 2'h1;
    endproperty
    a_first_not_early: assert property (p_first_not_early) else $error("first word early");
    property p_hold_output;
        r_edge && sel_chg |=> $stable(read_data)[*2];
    endproperty
    a_hold_output: assert property (p_hold_output) else $error("output changed on switch");
    property p_pr_bus;
        |(packet_ready_bus & ~$past(packet_ready_bus))
            |-> $past(wr_go && w_in[mqpr_pkg::END_BIT], 2);
    endproperty
    a_pr_bus: assert property (p_pr_bus) else $error("ready bit rose without packet");
    property p_ports_indep;
        !r_edge |=> $stable(read_data) && $stable(cur_sel);
    endproperty
    a_ports_indep: assert property (p_ports_indep) else $error("read side moved off edge");
    property p_qcount;
        (|push) |-> w_sel[4:0] <= qcnt && w_edge;
    endproperty
    a_qcount: assert property (p_qcount) else $error("write to unconfigured queue");
    property p_cascade;
        w_sel[7:5] != cid |-> push == '0;
    endproperty
    a_cascade: assert property (p_cascade) else $error("write to other device");
    property p_width;
        do_pop && rw == 2'h0 |=> read_data[35:9] == 27'h0;
    endproperty
    a_width: assert property (p_width) else $error("narrow read not masked");
    property p_markers;
        do_pop && rword[mqpr_pkg::END_BIT] && !push[cq] |=> pk[cq] == $past(pk[cq]) - 5'h1;
    endproperty
    a_markers: assert property (p_markers) else $error("end marker not counted");
    property p_refuse;
        do_pop |-> pk_nz[cq] && cur_ok;
    endproperty
    a_refuse: assert property (p_refuse) else $error("read without packet");
    property p_parked;
        s_park |=> output_valid_flag[*4];
    endproperty
    a_parked: assert property (p_parked) else $error("parked not empty");
endmodule
`default_nettype wire

// ---- dv/mqpr_ctl_model.sv ----
// Purpose: far-side controller driving the write and read port pins
// Assumes: both port clocks free-running at 125 ns, unrelated to aclk
// Notes:   pins change on aclk edges, well clear of port clock edges
`timescale 1ns/100ps
`default_nettype none
module mqpr_ctl_model (
    input  wire logic        aclk,
    output logic             write_port_clock,
    output logic             write_enable,
    output logic [7:0]       write_queue_sel,
    output logic [35:0]      write_data,
    output logic             read_port_clock,
    output logic             read_enable,
    output logic [7:0]       read_queue_sel
);
    initial begin
        write_port_clock = 1'b0;
        read_port_clock = 1'b0;
        write_enable = 1'b0;
        write_queue_sel = 8'hff;
        write_data = 36'h0;
        read_enable = 1'b0;
        read_queue_sel = 8'hff;
    end
    initial begin
        #33;
        forever #62.5 write_port_clock = ~write_port_clock;
    end
    initial begin
        #47;
        forever #62.5 read_port_clock = ~read_port_clock;
    end
    // one write on one write clock edge, then enable drops and the data lines are driven inverted
    task automatic wr(input logic [7:0] s, input logic [35:0] d);
        @(negedge write_port_clock);
        @(posedge aclk);
        write_enable <= 1'b1;
        write_queue_sel <= s;
        write_data <= d;
        @(negedge write_port_clock);
        @(posedge aclk);
        write_enable <= 1'b0;
        write_data <= ~d;
    endtask
    // one read clock edge with the given selection, enable dropped after it
    task automatic rd(input logic [7:0] s, input logic e);
        @(negedge read_port_clock);
        @(posedge aclk);
        read_queue_sel <= s;
        read_enable <= e;
        @(posedge read_port_clock);
        repeat (2) @(posedge aclk);
        read_enable <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: self-checking bench for the packet-mode queue read port
// Assumes: controller model drives the port pins
// Notes:   registers reached through an AXI4-Lite master in tasks
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, full_flag;
    logic output_valid_flag, packet_ready_flag;
    logic wep, wec, rdp, rde;
    logic [7:0] awaddr, araddr, wsel, rsel;
    logic [31:0] wdata, rdata, packet_ready_bus;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [35:0] wd, read_data;
    logic [31:0] d;
    int n_mismatch = 0;
    int checks = 0;

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    mqpr_ctl_model ctl (.aclk(aclk), .write_port_clock(wep), .write_enable(wec),
        .write_queue_sel(wsel), .write_data(wd), .read_port_clock(rdp),
        .read_enable(rde), .read_queue_sel(rsel));

    mqpr_read_port mqpr_read_port_inst (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq(irq), .write_port_clock(wep), .write_enable(wec),
        .write_queue_sel(wsel), .write_data(wd), .full_flag(full_flag),
        .read_port_clock(rdp), .read_enable(rde), .read_queue_sel(rsel),
        .read_data(read_data), .output_valid_flag(output_valid_flag),
        .packet_ready_flag(packet_ready_flag), .packet_ready_bus(packet_ready_bus));

    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        bit ad, wdn;
        ad = 0;
        wdn = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wdn)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wdn && wready === 1'b1) begin
                wdn = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    function automatic logic [35:0] pw(input int i, input logic [32:0] b);
        return {i == 5, i == 0, i == 1, b + 33'(i)};
    endfunction

    task automatic t_reset();
        chk("ov", 36'(output_valid_flag), 36'h1);
        chk("prbus", 36'(packet_ready_bus), 36'h0);
        chk("irq", 36'(irq), 36'h0);
        axi_rd(mqpr_pkg::OFS_CTRL, d, r);
        chk("ctrl", 36'(d), 36'(mqpr_pkg::CTRL_RST));
        axi_rd(mqpr_pkg::OFS_LIMIT, d, r);
        chk("limit", 36'(d), 36'(mqpr_pkg::LIM_RST));
        axi_rd(8'h18, d, r);
        chk("unmapped rresp", 36'(r), 36'(mqpr_pkg::RESP_SLVERR));
        axi_wr(8'h18, 32'h0, r);
        chk("unmapped bresp", 36'(r), 36'(mqpr_pkg::RESP_SLVERR));
        $display("test reset done");
    endtask

    task automatic t_fill();
        for (int i = 0; i < 6; i++) ctl.wr(8'h03, pw(i, 33'h0));
        for (int i = 0; i < 6; i++) ctl.wr(8'h03, pw(i, 33'h100));
        ctl.wr(8'h05, pw(0, 33'h200));
        repeat (8) @(posedge aclk);
        chk("prbus", 36'(packet_ready_bus), 36'h8);
        axi_rd(mqpr_pkg::OFS_PRDY, d, r);
        chk("prdy reg", 36'(d), 36'h8);
        axi_rd(mqpr_pkg::OFS_STAT, d, r);
        chk("stat pkt", 36'(d[0]), 36'h1);
        axi_wr(mqpr_pkg::OFS_MASK, 32'h1, r);
        repeat (2) @(posedge aclk);
        chk("irq set", 36'(irq), 36'h1);
        axi_wr(mqpr_pkg::OFS_STAT, 32'h1, r);
        repeat (2) @(posedge aclk);
        chk("irq clr", 36'(irq), 36'h0);
        axi_wr(mqpr_pkg::OFS_MASK, 32'h0, r);
        $display("test fill done");
    endtask

    task automatic t_read();
        ctl.rd(8'h05, 1'b1);
        ctl.rd(8'h05, 1'b1);
        chk("ov partial", 36'(output_valid_flag), 36'h1);
        ctl.rd(8'h03, 1'b0);
        ctl.rd(8'h03, 1'b0);
        chk("word early", read_data, 36'h0);
        ctl.rd(8'h03, 1'b0);
        chk("first word", read_data, pw(0, 33'h0));
        chk("ov low", 36'(output_valid_flag), 36'h0);
        for (int i = 1; i < 6; i++) begin
            ctl.rd(8'h03, 1'b1);
            chk("word", read_data, pw(i, 33'h0));
        end
        axi_rd(mqpr_pkg::OFS_STAT, d, r);
        chk("stat near end", 36'(d[3:0] & 4'ha), 36'ha);
        axi_wr(mqpr_pkg::OFS_STAT, 32'hf, r);
        $display("test read done");
    endtask

    task automatic t_park();
        ctl.rd(8'hff, 1'b1);
        ctl.rd(8'hff, 1'b1);
        chk("held word", read_data, pw(5, 33'h0));
        chk("ov parked", 36'(output_valid_flag), 36'h1);
        chk("prbus left", 36'(packet_ready_bus), 36'h8);
        ctl.wr(8'hff, 36'h1);
        repeat (8) @(posedge aclk);
        chk("full parked", 36'(full_flag), 36'h1);
        axi_rd(mqpr_pkg::OFS_STAT, d, r);
        chk("stat refused", 36'(d[2]), 36'h1);
        $display("test park done");
    endtask

    task automatic t_narrow();
        axi_wr(mqpr_pkg::OFS_CTRL, mqpr_pkg::CTRL_RST & ~(32'h3 << mqpr_pkg::CTRL_RW_L), r);
        chk("ctrl bresp", 36'(r), 36'(mqpr_pkg::RESP_OKAY));
        for (int i = 0; i < 3; i++) ctl.rd(8'h03, 1'b0);
        chk("narrow word", read_data, 36'h100);
        chk("ov narrow", 36'(output_valid_flag), 36'h0);
        ctl.rd(8'hff, 1'b0);
        chk("held narrow", read_data, 36'h100);
        $display("test narrow done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_fill();
        t_read();
        t_park();
        t_narrow();
        end_of_test();
    end
endmodule
`default_nettype wire
